// [dv/amtc_core_model.sv]
// Behavioural converter core that fills the result registers.
`timescale 1ns/1ps
module amtc_core_model #(
  parameter int unsigned RES_W = 10,
  parameter int unsigned NUM_RES = 8
) (
  input wire logic clk,
  input wire logic conv_soft_reset,
  output logic [NUM_RES-1:0] result_valid,
  output logic [NUM_RES*RES_W-1:0] result_data,
  output logic priority_valid,
  output logic [RES_W-1:0] priority_data
);
  initial begin
    result_valid = '0;
    result_data = '0;
    priority_valid = 1'b0;
    priority_data = '0;
  end
  // Stores one result with a one-cycle flag; index NUM_RES is the priority register.
  task automatic store(input int idx, input logic [RES_W-1:0] val);
    @(posedge clk);
    if (idx >= NUM_RES) begin
      priority_valid <= 1'b1;
      priority_data <= val;
    end else begin
      result_valid[idx] <= 1'b1;
      result_data[idx*RES_W +: RES_W] <= val;
    end
    @(posedge clk);
    result_valid <= '0;
    priority_valid <= 1'b0;
  endtask : store
  always @(posedge clk) if (conv_soft_reset) result_data <= '0;
endmodule : amtc_core_model

// [dv/amtc_props.sv]
// Port-level checks for the converter monitor and trigger control block.
`timescale 1ns/1ps
module amtc_props
  import amtc_pkg::*;
#(
  parameter int unsigned RES_W = 10,
  parameter int unsigned NUM_RES = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [amtc_pkg::AMTC_ADDR_W-1:0] addr,
  input wire logic [amtc_pkg::AMTC_DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic ext_trig,
  input wire logic timer_match_nrm,
  input wire logic timer_match_pri,
  input wire logic [NUM_RES-1:0] result_valid,
  input wire logic [NUM_RES*RES_W-1:0] result_data,
  input wire logic priority_valid,
  input wire logic [RES_W-1:0] priority_data,
  input wire logic nrm_start,
  input wire logic pri_start,
  input wire logic mon0_irq_pulse,
  input wire logic conv_soft_reset,
  input wire logic [amtc_pkg::AMTC_CLK_W-1:0] conversion_clock_setting
);
  import amtc_pkg::*;
  // ------------------------------------------------------------
  // Shadow copies of the control registers
  // ------------------------------------------------------------
  logic [3:0] ctl_reg;
  logic [5:0] cfg_reg;
  logic [RES_W-1:0] cmp_reg;
  logic armed_reg;
  wire wr_ctl = wr_en && addr == AMTC_OFS_TRIG_CTRL;
  wire [3:0] sel = cfg_reg[4:1];
  wire [RES_W-1:0] seen = sel[3] ? priority_data : result_data[sel[2:0]*RES_W +: RES_W];
  wire seen_v = sel[3] ? priority_valid : result_valid[sel[2:0]];
  wire hit = cfg_reg[0] && seen_v && (cfg_reg[5] ? seen > cmp_reg : seen < cmp_reg);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {ctl_reg, cfg_reg, cmp_reg, armed_reg} <= '0;
    end else if (conv_soft_reset) begin
      {ctl_reg, cfg_reg, cmp_reg, armed_reg} <= '0;
    end else if (wr_en) begin
      if (wr_ctl) {ctl_reg, armed_reg} <= {wdata[7:4], wdata[1:0] == AMTC_RST_FIRST};
      if (addr == AMTC_OFS_MON0_CFG) cfg_reg <= wdata[5:0];
      if (addr == AMTC_OFS_CMP0) cmp_reg <= wdata[RES_W-1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  nrm_timer_start_a: assert property (timer_match_nrm && ctl_reg[1:0] == 2'h3 |-> nrm_start)
    else $error("normal start missing after timer match");
  nrm_gate_a: assert property (!ctl_reg[0] |-> !nrm_start)
    else $error("normal start while disabled");
  pri_timer_start_a: assert property (timer_match_pri && ctl_reg[3:2] == 2'h3 |-> pri_start)
    else $error("priority start missing after timer match");
  pri_gate_a: assert property (!ctl_reg[2] |-> !pri_start)
    else $error("priority start while disabled");
  ext_nrm_start_a: assert property ($rose(ext_trig) && ctl_reg[1:0] == 2'h1 |-> ##[1:4] nrm_start)
    else $error("normal start missing after external edge");
  soft_reset_a: assert property (wr_ctl && wdata[1:0] == AMTC_RST_SECOND && armed_reg |=> conv_soft_reset)
    else $error("soft reset missing after ordered codes");
  reset_cause_a: assert property (conv_soft_reset |-> $past(wr_ctl) && $past(armed_reg))
    else $error("soft reset without ordered codes");
  clock_kept_a: assert property (conv_soft_reset |=> $stable(conversion_clock_setting))
    else $error("clock setting lost by soft reset");
  mon_hit_a: assert property (hit |=> mon0_irq_pulse)
    else $error("monitor pulse missing");
  mon_cause_a: assert property (mon0_irq_pulse |-> $past(hit))
    else $error("monitor pulse without hit");
endmodule : amtc_props
bind amtc_top amtc_props #(.RES_W(RES_W), .NUM_RES(NUM_RES)) u_amtc_props (.*);

// [dv/amtc_top_tb_top.sv]
// Self-checking bench for the converter monitor and trigger control block.
`timescale 1ns/1ps
module amtc_top_tb_top;
  import amtc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic ext_trig = 1'b0;
  logic timer_match_nrm = 1'b0;
  logic timer_match_pri = 1'b0;
  logic [AMTC_ADDR_W-1:0] addr = '0;
  logic [AMTC_DATA_W-1:0] wdata = '0;
  logic [AMTC_DATA_W-1:0] rdata;
  logic [AMTC_NUM_RES-1:0] result_valid;
  logic [AMTC_NUM_RES*AMTC_RES_W-1:0] result_data;
  logic priority_valid;
  logic [AMTC_RES_W-1:0] priority_data;
  logic nrm_start, pri_start, mon0_irq_pulse, conv_soft_reset, irq;
  logic [AMTC_CLK_W-1:0] conversion_clock_setting;
  logic [AMTC_DATA_W-1:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [3:0] sel;
  int unsigned cmp;
  int n_fail = 0;
  int checks_done = 0;
  int n_nrm = 0, n_pri = 0, n_mon = 0, n_srst = 0;
  amtc_top u_amtc_top (.*);
  amtc_core_model u_amtc_core_model (.*);
  initial forever #50 clk = ~clk;
  // ------------------------------------------------------------
  // Bus tasks and result watcher
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    exp_q.push_back(exp);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask : rd
  task automatic counts(input int nrm, input int pri, input int mon, input int srst);
    repeat (6) @(posedge clk);
    chk(n_nrm, nrm);
    chk(n_pri, pri);
    chk(n_mon, mon);
    chk(n_srst, srst);
    {n_nrm, n_pri, n_mon, n_srst} = '0;
  endtask : counts
  task automatic report_and_stop();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    if (rd_seen) chk(rdata, exp_q.pop_front());
    rd_seen <= rd_en;
    if (nrm_start === 1'b1) n_nrm++;
    if (pri_start === 1'b1) n_pri++;
    if (mon0_irq_pulse === 1'b1) n_mon++;
    if (conv_soft_reset === 1'b1) n_srst++;
  end
  initial begin
    #2000000;
    n_fail++;
    report_and_stop();
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(29));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 0; a < 32; a += 4) if (a != 24) rd(a[7:0], 32'h0);
    wr(AMTC_OFS_MON0_CFG, 32'hffffffff);
    rd(AMTC_OFS_MON0_CFG, 32'h3f);
    wr(AMTC_OFS_TRIG_CTRL, 32'hff);
    rd(AMTC_OFS_TRIG_CTRL, 32'hf0);
    wr(8'h1c, 32'hffffffff);
    wr(AMTC_OFS_INT_STATUS, 32'h7);
    rd(8'h1c, 32'h0);
    wr(AMTC_OFS_MON0_CFG, 32'h0);
    wr(AMTC_OFS_INT_CLEAR, 32'h7);
    wr(AMTC_OFS_INT_ENABLE, 32'h6);
    for (int i = 0; i < 16; i++) begin
      if (i[0] && !i[1] && i[2] && !i[3]) continue;
      wr(AMTC_OFS_TRIG_CTRL, i << 4);
      @(posedge clk);
      timer_match_nrm <= 1'b1;
      timer_match_pri <= 1'b1;
      @(posedge clk);
      timer_match_nrm <= 1'b0;
      timer_match_pri <= 1'b0;
      counts(i[0] && i[1], i[2] && i[3], 0, 0);
      ext_trig <= 1'b1;
      repeat (2) @(posedge clk);
      ext_trig <= 1'b0;
      counts(i[0] && !i[1], i[2] && !i[3], 0, 0);
    end
    @(negedge clk);
    chk(irq, 1'b1);
    wr(AMTC_OFS_INT_ENABLE, 32'h0);
    @(negedge clk);
    chk(irq, 1'b0);
    rd(AMTC_OFS_INT_STATUS, 32'h6);
    wr(AMTC_OFS_INT_CLEAR, 32'h6);
    rd(AMTC_OFS_INT_STATUS, 32'h0);
    wr(AMTC_OFS_TRIG_CTRL, 32'h0);
    for (int s = 0; s < 9; s++) begin
      for (int d = 0; d < 2; d++) begin
        cmp = $urandom_range(1022, 1);
        sel = (s == 8) ? 4'h8 | 4'($urandom_range(7, 0)) : 4'(s);
        wr(AMTC_OFS_CMP0, cmp);
        wr(AMTC_OFS_MON0_CFG, {d[0], sel, 1'b1});
        u_amtc_core_model.store(s, cmp[9:0]);
        u_amtc_core_model.store((s + 1) % 9, 10'(d ? cmp + 1 : cmp - 1));
        u_amtc_core_model.store(s, 10'(d ? cmp + 1 : cmp - 1));
        counts(0, 0, 1, 0);
      end
    end
    wr(AMTC_OFS_MON0_CFG, 32'h0);
    u_amtc_core_model.store(0, 10'h000);
    counts(0, 0, 0, 0);
    rd(AMTC_OFS_INT_STATUS, 32'h1);
    wr(AMTC_OFS_CONV_CLK, 32'h5);
    wr(AMTC_OFS_INT_ENABLE, 32'h7);
    wr(AMTC_OFS_TRIG_CTRL, 32'h2);
    wr(AMTC_OFS_TRIG_CTRL, 32'h0);
    wr(AMTC_OFS_TRIG_CTRL, 32'h1);
    counts(0, 0, 0, 0);
    wr(AMTC_OFS_TRIG_CTRL, 32'h72);
    wr(AMTC_OFS_TRIG_CTRL, 32'h71);
    counts(0, 0, 0, 1);
    rd(AMTC_OFS_TRIG_CTRL, 32'h0);
    rd(AMTC_OFS_CMP0, 32'h0);
    rd(AMTC_OFS_INT_ENABLE, 32'h0);
    rd(AMTC_OFS_CONV_CLK, 32'h5);
    chk(conversion_clock_setting, 4'h5);
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule : amtc_top_tb_top

// [src/amtc_mon_cmp.sv]
// Value monitor comparator for one monitor channel.
`timescale 1ns/1ps
module amtc_mon_cmp #(
  parameter int unsigned RES_W = 10,
  parameter int unsigned NUM_RES = 8
) (
  input wire logic enable,
  input wire logic direction,
  input wire logic [3:0] source_select,
  input wire logic [RES_W-1:0] compare,
  input wire logic [NUM_RES-1:0] result_valid,
  input wire logic [NUM_RES*RES_W-1:0] result_data,
  input wire logic priority_valid,
  input wire logic [RES_W-1:0] priority_data,
  output logic hit
);
  import amtc_pkg::*;
  logic use_pri;
  logic [2:0] idx;
  logic sel_valid;
  logic [RES_W-1:0] sel_data;
  logic cond;

  initial begin
    if (NUM_RES != 8 || RES_W < 1) $error("amtc_mon_cmp: unsupported parameters");
  end

  assign use_pri = source_select[3];
  assign idx = source_select[2:0];
  assign sel_valid = use_pri ? priority_valid : result_valid[idx];
  assign sel_data = use_pri ? priority_data : result_data[idx*RES_W +: RES_W];
  assign cond = direction ? (sel_data > compare) : (sel_data < compare);
  assign hit = enable & sel_valid & cond;
endmodule : amtc_mon_cmp

// [src/amtc_pkg.sv]
// Package of constants for the converter monitor and trigger control block.
package amtc_pkg;
  localparam int unsigned AMTC_ADDR_W = 8;
  localparam int unsigned AMTC_DATA_W = 32;
  localparam int unsigned AMTC_RES_W = 10;
  localparam int unsigned AMTC_NUM_RES = 8;
  localparam int unsigned AMTC_CLK_W = 4;
  // Register byte offsets.
  localparam logic [7:0] AMTC_OFS_MON0_CFG = 8'h00;
  localparam logic [7:0] AMTC_OFS_TRIG_CTRL = 8'h04;
  localparam logic [7:0] AMTC_OFS_CMP0 = 8'h08;
  localparam logic [7:0] AMTC_OFS_CONV_CLK = 8'h0c;
  localparam logic [7:0] AMTC_OFS_INT_STATUS = 8'h10;
  localparam logic [7:0] AMTC_OFS_INT_ENABLE = 8'h14;
  localparam logic [7:0] AMTC_OFS_INT_CLEAR = 8'h18;
  // Monitor 0 configuration fields.
  localparam int unsigned AMTC_MON0_EN_BIT = 0;
  localparam int unsigned AMTC_MON0_SEL_LSB = 1;
  localparam int unsigned AMTC_MON0_DIR_BIT = 5;
  localparam logic [5:0] AMTC_MON0_RESET = 6'h00;
  // Trigger control fields.
  localparam int unsigned AMTC_RST_LSB = 0;
  localparam int unsigned AMTC_NRM_EN_BIT = 4;
  localparam int unsigned AMTC_NRM_SRC_BIT = 5;
  localparam int unsigned AMTC_PRI_EN_BIT = 6;
  localparam int unsigned AMTC_PRI_SRC_BIT = 7;
  localparam logic [3:0] AMTC_TRIG_RESET = 4'h0;
  localparam logic [1:0] AMTC_RST_FIRST = 2'h2;
  localparam logic [1:0] AMTC_RST_SECOND = 2'h1;
  // Interrupt status bit positions.
  localparam int unsigned AMTC_IRQ_MON0 = 0;
  localparam int unsigned AMTC_IRQ_NRM = 1;
  localparam int unsigned AMTC_IRQ_PRI = 2;
  localparam int unsigned AMTC_IRQ_W = 3;
  localparam logic [9:0] AMTC_CMP_RESET = 10'h000;
  localparam logic [3:0] AMTC_CLK_RESET = 4'h0;
endpackage : amtc_pkg

// [src/amtc_top.sv]
// Converter monitor 0 and hardware trigger control with register port.
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module amtc_top #(
  parameter int unsigned RES_W = amtc_pkg::AMTC_RES_W,
  parameter int unsigned NUM_RES = amtc_pkg::AMTC_NUM_RES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [amtc_pkg::AMTC_ADDR_W-1:0] addr,
  input wire logic [amtc_pkg::AMTC_DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [amtc_pkg::AMTC_DATA_W-1:0] rdata,
  input wire logic ext_trig,
  input wire logic timer_match_nrm,
  input wire logic timer_match_pri,
  input wire logic [NUM_RES-1:0] result_valid,
  input wire logic [NUM_RES*RES_W-1:0] result_data,
  input wire logic priority_valid,
  input wire logic [RES_W-1:0] priority_data,
  output logic nrm_start,
  output logic pri_start,
  output logic mon0_irq_pulse,
  output logic conv_soft_reset,
  output logic [amtc_pkg::AMTC_CLK_W-1:0] conversion_clock_setting,
  output logic irq
);
  import amtc_pkg::*;

  initial begin
    if (NUM_RES != 8 || RES_W < 1 || RES_W > 16) $error("amtc_top: unsupported parameters");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic monitor0_enable_reg;
  logic [3:0] monitor0_source_select_reg;
  logic monitor0_direction_reg;
  logic priority_hw_source_reg;
  logic priority_hw_trigger_enable_reg;
  logic normal_hw_source_reg;
  logic normal_hw_trigger_enable_reg;
  logic [RES_W-1:0] cmp0_reg;
  logic [AMTC_CLK_W-1:0] clk_set_reg;
  logic [AMTC_IRQ_W-1:0] status_reg;
  logic [AMTC_IRQ_W-1:0] irq_en_reg;
  logic rst_armed_reg;
  logic soft_rst_reg;
  logic mon0_pulse_reg;
  logic [AMTC_DATA_W-1:0] rdata_reg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic wr_mon0;
  logic wr_trig;
  logic wr_cmp;
  logic wr_clk;
  logic wr_ien;
  logic wr_iclr;
  logic [1:0] rst_code;
  logic rst_match;
  logic mon0_hit;
  logic [AMTC_IRQ_W-1:0] events;
  logic [AMTC_IRQ_W-1:0] clr_mask;
  logic [AMTC_DATA_W-1:0] rd_mux;

  assign wr_mon0 = wr_en && addr == AMTC_OFS_MON0_CFG;
  assign wr_trig = wr_en && addr == AMTC_OFS_TRIG_CTRL;
  assign wr_cmp = wr_en && addr == AMTC_OFS_CMP0;
  assign wr_clk = wr_en && addr == AMTC_OFS_CONV_CLK;
  assign wr_ien = wr_en && addr == AMTC_OFS_INT_ENABLE;
  assign wr_iclr = wr_en && addr == AMTC_OFS_INT_CLEAR;
  assign rst_code = wdata[AMTC_RST_LSB +: 2];
  assign rst_match = wr_trig && rst_armed_reg && rst_code == AMTC_RST_SECOND;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // A software reset clears everything except the conversion clock setting.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      monitor0_enable_reg <= AMTC_MON0_RESET[AMTC_MON0_EN_BIT];
      monitor0_source_select_reg <= AMTC_MON0_RESET[AMTC_MON0_SEL_LSB +: 4];
      monitor0_direction_reg <= AMTC_MON0_RESET[AMTC_MON0_DIR_BIT];
      priority_hw_source_reg <= AMTC_TRIG_RESET[3];
      priority_hw_trigger_enable_reg <= AMTC_TRIG_RESET[2];
      normal_hw_source_reg <= AMTC_TRIG_RESET[1];
      normal_hw_trigger_enable_reg <= AMTC_TRIG_RESET[0];
      cmp0_reg <= RES_W'(AMTC_CMP_RESET);
      irq_en_reg <= '0;
    end else if (soft_rst_reg) begin
      monitor0_enable_reg <= AMTC_MON0_RESET[AMTC_MON0_EN_BIT];
      monitor0_source_select_reg <= AMTC_MON0_RESET[AMTC_MON0_SEL_LSB +: 4];
      monitor0_direction_reg <= AMTC_MON0_RESET[AMTC_MON0_DIR_BIT];
      priority_hw_source_reg <= AMTC_TRIG_RESET[3];
      priority_hw_trigger_enable_reg <= AMTC_TRIG_RESET[2];
      normal_hw_source_reg <= AMTC_TRIG_RESET[1];
      normal_hw_trigger_enable_reg <= AMTC_TRIG_RESET[0];
      cmp0_reg <= RES_W'(AMTC_CMP_RESET);
      irq_en_reg <= '0;
    end else begin
      if (wr_mon0) begin
        monitor0_enable_reg <= wdata[AMTC_MON0_EN_BIT];
        monitor0_source_select_reg <= wdata[AMTC_MON0_SEL_LSB +: 4];
        monitor0_direction_reg <= wdata[AMTC_MON0_DIR_BIT];
      end
      if (wr_trig) begin
        priority_hw_source_reg <= wdata[AMTC_PRI_SRC_BIT];
        priority_hw_trigger_enable_reg <= wdata[AMTC_PRI_EN_BIT];
        normal_hw_source_reg <= wdata[AMTC_NRM_SRC_BIT];
        normal_hw_trigger_enable_reg <= wdata[AMTC_NRM_EN_BIT];
      end
      if (wr_cmp) begin
        cmp0_reg <= wdata[RES_W-1:0];
      end
      if (wr_ien) begin
        irq_en_reg <= wdata[AMTC_IRQ_W-1:0];
      end
    end
  end

  // The conversion clock setting survives the software reset.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk_set_reg <= AMTC_CLK_RESET;
    end else if (wr_clk) begin
      clk_set_reg <= wdata[AMTC_CLK_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Two-step software reset sequencer
  // ----------------------------------------------------------------
  // Any write to the control register re-evaluates the arming state,
  // so the pair must be back to back among writes to that register.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_armed_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
    end else begin
      if (wr_trig) begin
        rst_armed_reg <= rst_code == AMTC_RST_FIRST;
      end else if (soft_rst_reg) begin
        rst_armed_reg <= 1'b0;
      end
      soft_rst_reg <= rst_match;
    end
  end

  // ----------------------------------------------------------------
  // Trigger paths
  // ----------------------------------------------------------------
  // Software keeps the external trigger on one conversion kind only;
  // if both select it, both kinds start from the same edge.
  amtc_trig_sel u_trig_nrm (
    .clk(clk),
    .resetn(resetn),
    .ext_trig(ext_trig),
    .timer_match(timer_match_nrm),
    .source_sel(normal_hw_source_reg),
    .enable(normal_hw_trigger_enable_reg),
    .start(nrm_start)
  );

  amtc_trig_sel u_trig_pri (
    .clk(clk),
    .resetn(resetn),
    .ext_trig(ext_trig),
    .timer_match(timer_match_pri),
    .source_sel(priority_hw_source_reg),
    .enable(priority_hw_trigger_enable_reg),
    .start(pri_start)
  );

  // ----------------------------------------------------------------
  // Monitor 0
  // ----------------------------------------------------------------
  amtc_mon_cmp #(
    .RES_W(RES_W),
    .NUM_RES(NUM_RES)
  ) u_mon0 (
    .enable(monitor0_enable_reg),
    .direction(monitor0_direction_reg),
    .source_select(monitor0_source_select_reg),
    .compare(cmp0_reg),
    .result_valid(result_valid),
    .result_data(result_data),
    .priority_valid(priority_valid),
    .priority_data(priority_data),
    .hit(mon0_hit)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mon0_pulse_reg <= 1'b0;
    end else begin
      mon0_pulse_reg <= mon0_hit & ~soft_rst_reg;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  assign events = {pri_start, nrm_start, mon0_pulse_reg};
  assign clr_mask = wr_iclr ? wdata[AMTC_IRQ_W-1:0] : '0;

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_reg <= '0;
    end else if (soft_rst_reg) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~clr_mask) | events;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    case (addr)
      AMTC_OFS_MON0_CFG: begin
        rd_mux[AMTC_MON0_EN_BIT] = monitor0_enable_reg;
        rd_mux[AMTC_MON0_SEL_LSB +: 4] = monitor0_source_select_reg;
        rd_mux[AMTC_MON0_DIR_BIT] = monitor0_direction_reg;
      end
      AMTC_OFS_TRIG_CTRL: begin
        rd_mux[AMTC_PRI_SRC_BIT] = priority_hw_source_reg;
        rd_mux[AMTC_PRI_EN_BIT] = priority_hw_trigger_enable_reg;
        rd_mux[AMTC_NRM_SRC_BIT] = normal_hw_source_reg;
        rd_mux[AMTC_NRM_EN_BIT] = normal_hw_trigger_enable_reg;
      end
      AMTC_OFS_CMP0: rd_mux[RES_W-1:0] = cmp0_reg;
      AMTC_OFS_CONV_CLK: rd_mux[AMTC_CLK_W-1:0] = clk_set_reg;
      AMTC_OFS_INT_STATUS: rd_mux[AMTC_IRQ_W-1:0] = status_reg;
      AMTC_OFS_INT_ENABLE: rd_mux[AMTC_IRQ_W-1:0] = irq_en_reg;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rd_en ? rd_mux : '0;
    end
  end

  assign rdata = rdata_reg;
  assign mon0_irq_pulse = mon0_pulse_reg;
  assign conv_soft_reset = soft_rst_reg;
  assign conversion_clock_setting = clk_set_reg;
  assign irq = |(status_reg & irq_en_reg);
endmodule : amtc_top

// [src/amtc_trig_sel.sv]
// Hardware trigger source selection and gating for one conversion kind.
`timescale 1ns/1ps
module amtc_trig_sel (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ext_trig,
  input wire logic timer_match,
  input wire logic source_sel,
  input wire logic enable,
  output logic start
);
  import amtc_pkg::*;
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic ext_rise;
  logic selected;

  // The external pin is synchronised; rising edges are the trigger events.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= ext_trig;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign ext_rise = sync2_reg & ~sync3_reg;
  assign selected = source_sel ? timer_match : ext_rise;
  assign start = enable & selected;
endmodule : amtc_trig_sel
